/* rtl/ecp_port_defs.vh */
// register offsets, field positions, reset values and timing counts of the extended port
`ifndef ECP_PORT_DEFS_VH
`define ECP_PORT_DEFS_VH
`define OFS_DATA        3'h0
`define OFS_STATUS      3'h1
`define OFS_CONTROL     3'h2
`define OFS_FIFO_CFGA   3'h3
`define OFS_CFGB        3'h4
`define OFS_EXT_CTRL    3'h5
`define OFS_NONE        3'h7
`define MODE_STD        3'h0
`define MODE_PS2        3'h1
`define MODE_PFIFO      3'h2
`define MODE_EFIFO      3'h3
`define MODE_TEST       3'h6
`define MODE_CFG        3'h7
`define CFG_EN_BIT      2
`define CTL_DIR_BIT     5
`define CTL_AFD_BIT     1
`define CTL_STB_BIT     0
`define ECR_DMAEN_BIT   3
`define ECR_SERV_BIT    2
`define ECR_RESET       8'h15
`define CTL_RESET       8'h04
`define CFGA_VALUE      8'h14
`define CFGB_VALUE      8'h08
`define BASE_0          8'h9E
`define BASE_1          8'hDE
`define BASE_2          8'hEF
`define DMA_BURST_MAX   6'd32
`define SETTLE_NS       20
`define SETTLE_CYC      (((`SETTLE_NS) + 9) / 10)
`endif

/* rtl/ecp_fifo_ctrl.v */
// extended capabilities parallel port: register decode, tagged fifo, dma and cycle control
`timescale 1ns/1ps
// Function
// - sixteen-byte fifo either direction, command/data tag, full/empty, hardware strobes
// - port active only with enable bit 2; mode from extended control bits 7..5
// - all fifo register views reach one shared fifo at offset 0 or 3
// - dma requests when enabled and service clear; fill forward, drain backward
// - dma request dropped after at most 32 consecutive dma cycles
// - terminal count during dma cycle stops further requests
// - write to full dropped, read of empty undefined, flags unchanged
// - access to unavailable register has no effect
// - legacy status and control reachable in every mode; data register replaced outside modes 000/001
// - handshake lines sampled only after data lines settle
// - decode uses a9, a1, a0 and mode field
// - base address from a2..a8, one of three selectable values
// - leaving backward mode 011 mid-read aborts cycle, empties fifo
// - zero-wait response asserted on any register access while enabled
// - frozen clock disables dma, ignores fifo accesses
// - frozen clock reads service 0, full 1, empty 1; contents kept
// - frozen clock starts no new peripheral cycle
// - all port outputs inactive while disabled
// - leaving mode 010/011 resets fifo and dma, even when frozen
// - extended control resets to 00010101
// - direction bit 5: 0 forward drives data lines, 1 backward releases them in modes 001, 011 and 110 only
`include "ecp_port_defs.vh"
module ecp_fifo_ctrl #(
   parameter DEPTH = 16,
   parameter AW    = 4
)(
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       portEnable,
   input  wire [1:0] baseSelect,
   input  wire       clkFrozen,
   input  wire [9:0] hostAddr,
   input  wire       hostRdStrobe,
   input  wire       hostWrStrobe,
   input  wire [7:0] hostWrData,
   input  wire       dmaAck,
   input  wire       termCount,
   input  wire [7:0] perDataIn,
   input  wire       perBusy,
   input  wire       perAck,
   input  wire [4:0] perStatus,
   output reg  [7:0] hostRdData,
   output reg        hostRdValid,
   output reg        zeroWaitOut,
   output reg        dmaReq,
   output reg  [7:0] perDataOut,
   output reg        perDataOe,
   output reg        strobeOut,
   output reg        autofeedOut,
   output reg        fifoFullOut,
   output reg        fifoEmptyOut
);
   // ---------------------------------------------
   // register decode
   // ---------------------------------------------
   reg  [7:0]    ctl_q;
   reg  [7:0]    ecr_q;
   reg  [7:0]    dataLatch_q;
   wire [2:0]    mode = ecr_q[7:5];
   wire          dirBack = ctl_q[`CTL_DIR_BIT] & (mode == `MODE_EFIFO || mode == `MODE_TEST || mode == `MODE_PS2);
   wire [7:0]    baseWord = (baseSelect == 2'd0) ? `BASE_0 :
                            (baseSelect == 2'd1) ? `BASE_1 : `BASE_2;
   // bank select takes the a9 slot; every selectable base has that bit set
   wire          hit = portEnable & ({1'b1, hostAddr[8:2]} == baseWord);
   reg  [2:0]    regIdx;
   always @*
   begin
      case ({hostAddr[9], hostAddr[1], hostAddr[0]})
         3'b000:  regIdx = `OFS_DATA;
         3'b001:  regIdx = `OFS_STATUS;
         3'b010:  regIdx = `OFS_CONTROL;
         default: regIdx = `OFS_NONE;
      endcase
   end
   wire          hiBank = hostAddr[9];
   wire          acc = hit & (hostRdStrobe | hostWrStrobe);
   wire [2:0]    idx = hiBank ? (hostAddr[1] ? (hostAddr[0] ? `OFS_NONE : `OFS_EXT_CTRL) :
                                 (hostAddr[0] ? `OFS_CFGB : `OFS_FIFO_CFGA)) : regIdx;
   // ---------------------------------------------
   // fifo store
   // ---------------------------------------------
   reg  [8:0]    mem [0:DEPTH-1];
   reg  [AW-1:0] wp_q;
   reg  [AW-1:0] rp_q;
   reg  [AW:0]   cnt_q;
   wire          full  = (cnt_q == DEPTH[AW:0]);
   wire          empty = (cnt_q == {(AW+1){1'b0}});
   wire          fifoMode = (mode == `MODE_PFIFO) | (mode == `MODE_EFIFO) | (mode == `MODE_TEST);
   wire          fifoView = ~clkFrozen & fifoMode;
   wire          hostPushD = acc & hostWrStrobe & fifoView & idx == `OFS_FIFO_CFGA &
                             (mode == `MODE_TEST | ~dirBack);
   wire          hostPushA = acc & hostWrStrobe & ~clkFrozen & mode == `MODE_EFIFO &
                             idx == `OFS_DATA & ~dirBack;
   wire          hostPop   = acc & hostRdStrobe & fifoView & idx == `OFS_FIFO_CFGA &
                             (mode == `MODE_TEST | (mode == `MODE_EFIFO & dirBack));
   reg           perPush;
   reg           perPop;
   wire          dmaXfer = dmaReq & dmaAck;
   wire          tcSet   = dmaXfer & termCount;
   wire          dmaPush = dmaXfer & ~dirBack;
   wire          dmaPop  = dmaXfer & dirBack;
   wire          pushReq = hostPushD | hostPushA | dmaPush | perPush;
   wire          popReq  = hostPop | dmaPop | perPop;
   wire          doPush = pushReq & ~full;
   wire          doPop  = popReq & ~empty;
   wire [8:0]    pushWord = perPush ? {1'b0, perDataIn} :
                            {hostPushA, hostWrData};
   reg  [2:0]    prevMode_q;
   wire          leaveFifo = (prevMode_q == `MODE_PFIFO || prevMode_q == `MODE_EFIFO) &&
                             (mode != `MODE_PFIFO && mode != `MODE_EFIFO);
   wire          flush = leaveFifo | ~portEnable | mode == `MODE_STD | mode == `MODE_PS2;
   always @(posedge ref_clk)
   begin
      if (doPush)
      begin
         mem[wp_q] <= pushWord;
      end
   end
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else if (flush)
      begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (doPush)
         begin
            wp_q <= wp_q + 1'b1;
         end
         if (doPop)
         begin
            rp_q <= rp_q + 1'b1;
         end
         if (doPush & ~doPop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (doPop & ~doPush)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
   // ---------------------------------------------
   // register writes
   // ---------------------------------------------
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctl_q       <= `CTL_RESET;
         ecr_q       <= `ECR_RESET;
         dataLatch_q <= 8'h00;
         prevMode_q  <= 3'h0;
      end
      else
      begin
         prevMode_q <= mode;
         if (acc & hostWrStrobe)
         begin
            if (idx == `OFS_CONTROL)
            begin
               ctl_q <= hostWrData;
            end
            if (idx == `OFS_DATA && (mode == `MODE_STD || mode == `MODE_PS2))
            begin
               dataLatch_q <= hostWrData;
            end
            if (idx == `OFS_EXT_CTRL)
            begin
               ecr_q <= {hostWrData[7:2], ecr_q[1:0]};
            end
         end
         if (tcSet)
         begin
            ecr_q[`ECR_SERV_BIT] <= 1'b1;
         end
      end
   end
   // ---------------------------------------------
   // dma request
   // ---------------------------------------------
   reg  [5:0]    burst_q;
   wire          dmaGo = ecr_q[`ECR_DMAEN_BIT] & ~ecr_q[`ECR_SERV_BIT] & ~clkFrozen &
                         (mode == `MODE_PFIFO | mode == `MODE_EFIFO) & ~flush;
   // a transfer under way counts already, so the request falls before the fifo overruns
   wire          need  = dirBack ? (dmaXfer ? (cnt_q > {{AW{1'b0}}, 1'b1}) : ~empty) :
                                   (dmaXfer ? (cnt_q < DEPTH[AW:0] - 1'b1) : ~full);
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         dmaReq  <= 1'b0;
         burst_q <= 6'd0;
      end
      else
      begin
         if (dmaXfer)
         begin
            burst_q <= burst_q + 6'd1;
         end
         else if (~dmaReq)
         begin
            burst_q <= 6'd0;
         end
         if (tcSet | (dmaXfer & burst_q == `DMA_BURST_MAX - 6'd1))
         begin
            dmaReq <= 1'b0;
         end
         else
         begin
            dmaReq <= dmaGo & need & (dmaReq | burst_q == 6'd0);
         end
      end
   end
   // ---------------------------------------------
   // peripheral cycle engine
   // ---------------------------------------------
   localparam ST_IDLE = 2'd0;
   localparam ST_SETL = 2'd1;
   localparam ST_WAIT = 2'd2;
   localparam ST_DONE = 2'd3;
   localparam integer SETTLE_W = `SETTLE_CYC;
   reg  [1:0]    st_q;
   reg  [3:0]    setl_q;
   wire          perFwd = (mode == `MODE_PFIFO | mode == `MODE_EFIFO) & ~dirBack;
   wire          perBck = (mode == `MODE_EFIFO) & dirBack;
   always @*
   begin
      perPush = 1'b0;
      perPop  = 1'b0;
      if (st_q == ST_WAIT && setl_q == 4'd0 && perAck && ~flush)
      begin
         perPush = perBck;
         perPop  = perFwd;
      end
   end
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q        <= ST_IDLE;
         setl_q      <= 4'd0;
         strobeOut   <= 1'b0;
         autofeedOut <= 1'b0;
         perDataOut  <= 8'h00;
         perDataOe   <= 1'b0;
      end
      else if (~portEnable)
      begin
         st_q        <= ST_IDLE;
         strobeOut   <= 1'b0;
         autofeedOut <= 1'b0;
         perDataOe   <= 1'b0;
      end
      else
      begin
         perDataOe <= ~dirBack;
         if (~fifoMode)
         begin
            perDataOut <= dataLatch_q;
         end
         case (st_q)
            ST_IDLE:
            begin
               strobeOut   <= ctl_q[`CTL_STB_BIT];
               autofeedOut <= ctl_q[`CTL_AFD_BIT];
               if (~clkFrozen & ~flush & ~perBusy &
                   ((perFwd & ~empty) | (perBck & ~full)))
               begin
                  perDataOut <= mem[rp_q][7:0];
                  if (perFwd)
                  begin
                     autofeedOut <= ~mem[rp_q][8];
                  end
                  setl_q <= SETTLE_W[3:0];
                  st_q   <= ST_SETL;
               end
            end
            ST_SETL:
            begin
               strobeOut <= perFwd;
               if (perBck)
               begin
                  autofeedOut <= 1'b1;
               end
               st_q <= ST_WAIT;
            end
            ST_WAIT:
            begin
               if (setl_q != 4'd0)
               begin
                  setl_q <= setl_q - 4'd1;
               end
               else if (flush)
               begin
                  autofeedOut <= 1'b0;
                  strobeOut   <= 1'b0;
                  st_q        <= ST_IDLE;
               end
               else if (perAck)
               begin
                  strobeOut   <= 1'b0;
                  autofeedOut <= 1'b0;
                  st_q        <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               if (~perAck)
               begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   // ---------------------------------------------
   // host read path
   // ---------------------------------------------
   reg  [7:0]    rdMux;
   always @*
   begin
      rdMux = 8'h00;
      case (idx)
         `OFS_DATA:      rdMux = (mode == `MODE_STD || mode == `MODE_PS2) ? perDataIn : 8'h00;
         `OFS_STATUS:    rdMux = {perBusy, perAck, perStatus[4:3], 1'b0, perStatus[2:0]};
         `OFS_CONTROL:   rdMux = ctl_q;
         `OFS_FIFO_CFGA: rdMux = hostPop ? mem[rp_q][7:0] : (mode == `MODE_CFG ? `CFGA_VALUE : 8'h00);
         `OFS_CFGB:      rdMux = (mode == `MODE_CFG) ? `CFGB_VALUE : 8'h00;
         `OFS_EXT_CTRL:  rdMux = clkFrozen ? {ecr_q[7:3], 3'b011} :
                                 {ecr_q[7:2], full, empty};
         default:        rdMux = 8'h00;
      endcase
   end
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         hostRdData   <= 8'h00;
         hostRdValid  <= 1'b0;
         zeroWaitOut  <= 1'b0;
         fifoFullOut  <= 1'b0;
         fifoEmptyOut <= 1'b1;
      end
      else
      begin
         hostRdValid  <= acc & hostRdStrobe;
         zeroWaitOut  <= acc;
         fifoFullOut  <= full;
         fifoEmptyOut <= empty;
         if (acc & hostRdStrobe)
         begin
            hostRdData <= rdMux;
         end
      end
   end
endmodule // ecp_fifo_ctrl

/* tb/ecp_fifo_ctrl_chk.sv */
// assertions on the pins of the extended port controller
`timescale 1ns/1ps
`include "ecp_port_defs.vh"
module ecp_fifo_ctrl_chk (
   input wire       ref_clk,
   input wire       rst,
   input wire       portEnable,
   input wire [1:0] baseSelect,
   input wire       clkFrozen,
   input wire [9:0] hostAddr,
   input wire       hostRdStrobe,
   input wire       hostWrStrobe,
   input wire       dmaAck,
   input wire       termCount,
   input wire       hostRdValid,
   input wire       zeroWaitOut,
   input wire       dmaReq,
   input wire       perDataOe,
   input wire       strobeOut,
   input wire       autofeedOut
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire [7:0] baseW = (baseSelect == 2'h0) ? `BASE_0 : (baseSelect == 2'h1) ? `BASE_1 : `BASE_2;
   // control exists in every mode, so a hit there must always be answered
   wire       ctlHit = portEnable && (hostAddr == {1'b0, baseW[6:0], 2'h2});
   reg  [6:0] burstQ;
   always @(posedge ref_clk or posedge rst)
      if (rst)
         burstQ <= 7'h00;
      else
         burstQ <= (dmaReq && dmaAck) ? burstQ + 7'h01 : 7'h00;
   // ------
   // properties
   // ------
   property p_zws; (hostRdStrobe || hostWrStrobe) && ctlHit |=> zeroWaitOut; endproperty
   a_zws: assert property (p_zws) else $error("access without zero-wait reply");
   property p_rdv; hostRdStrobe && ctlHit |=> hostRdValid; endproperty
   a_rdv: assert property (p_rdv) else $error("read without valid data");
   property p_nozws; !portEnable |=> !zeroWaitOut; endproperty
   a_nozws: assert property (p_nozws) else $error("zero-wait reply while disabled");
   property p_idle; !portEnable [*2] |-> !dmaReq && !perDataOe && !strobeOut && !autofeedOut; endproperty
   a_idle: assert property (p_idle) else $error("output active while disabled");
   property p_burst; burstQ <= 7'h20; endproperty
   a_burst: assert property (p_burst) else $error("dma burst too long");
   property p_tc; dmaReq && dmaAck && termCount |=> !dmaReq [*4]; endproperty
   a_tc: assert property (p_tc) else $error("dma request after terminal count");
   property p_frzdma; clkFrozen |=> !dmaReq; endproperty
   a_frzdma: assert property (p_frzdma) else $error("dma request while frozen");
   property p_frzcyc; clkFrozen && !strobeOut |=> !strobeOut; endproperty
   a_frzcyc: assert property (p_frzcyc) else $error("cycle started while frozen");
endmodule // ecp_fifo_ctrl_chk
bind ecp_fifo_ctrl ecp_fifo_ctrl_chk u_chk (.ref_clk, .rst, .portEnable, .baseSelect, .clkFrozen, .hostAddr,
   .hostRdStrobe, .hostWrStrobe, .dmaAck, .termCount, .hostRdValid, .zeroWaitOut, .dmaReq, .perDataOe,
   .strobeOut, .autofeedOut);

/* tb/ecp_peripheral_model.sv */
// behavioural peripheral on the cable side, both directions
`timescale 1ns/1ps
module ecp_peripheral_model (
   input  wire       ref_clk,
   input  wire       rst,
   input  wire [7:0] perDataOut,
   input  wire       perDataOe,
   input  wire       strobeOut,
   input  wire       autofeedOut,
   input  wire       stall,
   input  wire       slow,
   output wire [7:0] perDataIn,
   output wire       perBusy,
   output reg        perAck
);
   logic [7:0] rxQ[$];
   logic [7:0] txQ[$];
   logic [7:0] nxt;
   logic       armed;
   int         cnt;
   wire        req = strobeOut || autofeedOut;
   // released lines show the inverse of the last byte so a stale sample is caught
   assign perDataIn = (perAck || (req && armed)) ? nxt : ~(nxt - 8'h3B);
   assign perBusy   = perAck || stall;
   always @(posedge ref_clk or posedge rst)
      if (rst)
      begin
         perAck <= 1'b0;
         armed  <= 1'b1;
         cnt    <= 0;
         nxt    <= 8'hA5;
      end
      else if (!perAck)
      begin
         armed <= armed || !req;
         cnt   <= (req && armed && !stall) ? cnt + 1 : 0;
         if (req && armed && !stall && cnt >= (slow ? 3 : 1))
         begin
            perAck <= 1'b1;
            armed  <= 1'b0;
            cnt    <= 0;
            if (perDataOe)
               rxQ.push_back(perDataOut);
            else
               txQ.push_back(nxt);
         end
      end
      else
      begin
         cnt <= cnt + 1;
         if (!req || cnt == 3)
         begin
            perAck <= 1'b0;
            cnt    <= 0;
            nxt    <= nxt + 8'h3B;
         end
      end
endmodule // ecp_peripheral_model

/* tb/ecp_fifo_ctrl_tb.sv */
// self-checking bench for the extended port controller
`timescale 1ns/1ps
`include "ecp_port_defs.vh"
module ecp_fifo_ctrl_tb;
   logic       ref_clk = 1'b0, rst = 1'b1, portEnable = 1'b0, clkFrozen = 1'b0, stall = 1'b0, slow = 1'b0;
   logic       hostRdStrobe = 1'b0, hostWrStrobe = 1'b0, dmaAck = 1'b0, termCount = 1'b0, tr;
   logic [1:0] baseSelect = 2'h0;
   logic [9:0] hostAddr = 10'h000;
   logic [7:0] hostWrData = 8'h00, rdv, wd;
   logic [4:0] perStatus = 5'h00;
   logic [6:0] skew = 7'h00;
   wire  [7:0] hostRdData, perDataOut, perDataIn;
   wire        hostRdValid, zeroWaitOut, dmaReq, perDataOe, strobeOut, autofeedOut;
   wire        fifoFullOut, fifoEmptyOut, perBusy, perAck;
   wire  [7:0] baseW = (baseSelect == 2'h0) ? `BASE_0 : (baseSelect == 2'h1) ? `BASE_1 : `BASE_2;
   int         errors = 0, comparisons = 0, i, seedv;
   logic [7:0] q[$];
   ecp_fifo_ctrl dut (.ref_clk, .rst, .portEnable, .baseSelect, .clkFrozen, .hostAddr, .hostRdStrobe,
      .hostWrStrobe, .hostWrData, .dmaAck, .termCount, .perDataIn, .perBusy, .perAck, .perStatus, .hostRdData,
      .hostRdValid, .zeroWaitOut, .dmaReq, .perDataOut, .perDataOe, .strobeOut, .autofeedOut, .fifoFullOut,
      .fifoEmptyOut);
   ecp_peripheral_model per (.ref_clk, .rst, .perDataOut, .perDataOe, .strobeOut, .autofeedOut, .stall,
      .slow, .perDataIn, .perBusy, .perAck);
   always #5 ref_clk = ~ref_clk;
   // ------
   // bus tasks
   // ------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic bank, input logic [1:0] lo, input logic [7:0] d);
      @(negedge ref_clk);
      hostAddr = {bank, baseW[6:0] ^ skew, lo};
      hostWrData = d;
      hostWrStrobe = wr;
      hostRdStrobe = !wr;
      @(negedge ref_clk);
      hostWrStrobe = 1'b0;
      hostRdStrobe = 1'b0;
      rdv = hostRdData;
   endtask
   task automatic extended_control(input logic [2:0] m, input logic dma, input logic serv);
      acc(1'b1, 1'b1, 2'h2, {m, 1'b1, dma, serv, 2'b00});
   endtask
   task summarize;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      errors++;
      summarize;
   end
   initial
   begin
      seedv = $urandom(81);
      baseSelect = 2'($urandom_range(3));
      perStatus = 5'($urandom);
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      portEnable = 1'b1;
      acc(1'b0, 1'b1, 2'h2, 8'h00);
      chk(rdv, `ECR_RESET);
      acc(1'b0, 1'b0, 2'h2, 8'h00);
      chk(rdv, `CTL_RESET);
      skew = 7'h01;
      extended_control(3'h7, 1'b0, 1'b1);
      skew = 7'h00;
      acc(1'b0, 1'b1, 2'h2, 8'h00);
      chk(rdv, `ECR_RESET);
      acc(1'b0, 1'b1, 2'h1, 8'h00);
      chk(rdv, 8'h00);
      extended_control(3'h1, 1'b0, 1'b1);
      extended_control(3'h7, 1'b0, 1'b1);
      acc(1'b0, 1'b1, 2'h0, 8'h00);
      chk(rdv, `CFGA_VALUE);
      acc(1'b0, 1'b1, 2'h1, 8'h00);
      chk(rdv, `CFGB_VALUE);
      extended_control(3'h1, 1'b0, 1'b1);
      $display("decode test done");
      extended_control(3'h6, 1'b0, 1'b1);
      for (i = 0; i < 17; i++)
      begin
         wd = 8'($urandom);
         acc(1'b1, 1'b1, 2'h0, wd);
         if (q.size() < 16) q.push_back(wd);
      end
      @(negedge ref_clk);
      chk({7'h00, fifoFullOut}, 8'h01);
      clkFrozen = 1'b1;
      acc(1'b0, 1'b1, 2'h2, 8'h00);
      chk({5'h00, rdv[2:0]}, 8'h03);
      acc(1'b0, 1'b1, 2'h0, 8'h00);
      clkFrozen = 1'b0;
      acc(1'b0, 1'b1, 2'h2, 8'h00);
      chk({5'h00, rdv[2:0]}, 8'h06);
      while (q.size() > 0)
      begin
         acc(1'b0, 1'b1, 2'h0, 8'h00);
         chk(rdv, q.pop_front());
      end
      acc(1'b0, 1'b1, 2'h0, 8'h00);
      @(negedge ref_clk);
      chk({7'h00, fifoEmptyOut}, 8'h01);
      extended_control(3'h1, 1'b0, 1'b1);
      $display("fifo test done");
      extended_control(3'h2, 1'b1, 1'b0);
      dmaAck = 1'b1;
      tr = 1'b0;
      for (i = 0; i < 4000 && q.size() < 40; i++)
      begin
         @(negedge ref_clk);
         if (tr) q.push_back(wd);
         tr = dmaReq;
         termCount = dmaReq && q.size() == 39;
         wd = 8'($urandom);
         hostWrData = wd;
         slow = 1'($urandom);
      end
      dmaAck = 1'b0;
      for (i = 0; i < 2000 && !(fifoEmptyOut && !strobeOut && !perAck); i++) @(negedge ref_clk);
      chk({7'h00, dmaReq}, 8'h00);
      chk(8'(per.rxQ.size()), 8'h28);
      while (per.rxQ.size() > 0 && q.size() > 0) chk(per.rxQ.pop_front(), q.pop_front());
      acc(1'b0, 1'b1, 2'h2, 8'h00);
      chk({7'h00, rdv[2]}, 8'h01);
      stall = 1'b1;
      for (i = 0; i < 3; i++) acc(1'b1, 1'b1, 2'h0, 8'($urandom));
      @(negedge ref_clk);
      chk({7'h00, fifoEmptyOut}, 8'h00);
      extended_control(3'h0, 1'b0, 1'b1);
      repeat (2) @(negedge ref_clk);
      chk({7'h00, fifoEmptyOut}, 8'h01);
      stall = 1'b0;
      $display("dma test done");
      extended_control(3'h1, 1'b0, 1'b1);
      acc(1'b1, 1'b0, 2'h2, 8'h24);
      extended_control(3'h3, 1'b0, 1'b1);
      for (i = 0; i < 2000 && !fifoFullOut; i++) @(negedge ref_clk);
      chk({7'h00, perDataOe}, 8'h00);
      repeat (16)
      begin
         acc(1'b0, 1'b1, 2'h0, 8'h00);
         chk(rdv, per.txQ.pop_front());
      end
      for (i = 0; i < 200 && !autofeedOut; i++) @(negedge ref_clk);
      // hold the peripheral off only once a backward cycle is under way
      stall = 1'b1;
      chk({7'h00, autofeedOut}, 8'h01);
      extended_control(3'h1, 1'b0, 1'b1);
      repeat (2) @(negedge ref_clk);
      chk({6'h00, autofeedOut, fifoEmptyOut}, 8'h01);
      stall = 1'b0;
      $display("backward test done");
      portEnable = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk({5'h00, dmaReq, strobeOut, perDataOe}, 8'h00);
      $display("disable test done");
      summarize;
   end
endmodule // ecp_fifo_ctrl_tb
